/* File: bsc_defs.svh */
// constants of the boundary-scan cell chain: lengths, cell masks, enable cell positions
// assumes the includer indexes the chain as bit k-1 for cell k, bit 0 next to the serial input
//
// Operation
// - cells chained serially, cell 1 at serial input, higher cells toward serial output.
// - cells 1-2 are enable/config inputs, 16-17 size outputs, 18-46 address bits 0-28.
// - cells 3-4 gated by cell 1, other outputs by cell 15, cell 14 ungated.
// - chain contents after power-up are undefined; nobody may rely on them.
// - chain contents need not survive a test reset.
// - serial output driver turns on on entering shift-dr or shift-ir.
// - serial output returns to high impedance on leaving shift-dr or shift-ir.
// - under sample/preload and extest, cells capture on rising test clock in capture-dr.
// - test clock may halt in either phase indefinitely without losing state.
// - in test control, enable cells replace core enables on the output drivers.
// - under extest, updated latches drive pins and core at once.
// - under sample/preload, updated latches reach neither pins nor core.
// - under clamp, outputs come from existing latches, which stay unchanged.
`ifndef BSC_DEFS_SVH
`define BSC_DEFS_SVH

// ==========================================================
// chain geometry
`define CHAIN_LEN 46
`define CHAIN_MSB 45
`define MSE_BIT 0
`define ABE_BIT 14

// ==========================================================
// cell masks, bit k-1 for cell k
`define IN_MASK 46'h0000_0000_5f83
`define OUT_MASK 46'h3fff_ffff_a07c
`define MSE_GATED 46'h0000_0000_000c
`define ABE_GATED 46'h3fff_ffff_8070
`define UNGATED 46'h0000_0000_2000

// ==========================================================
// snapshot buffer
`define SNAP_DEPTH 8

`endif

/* File: bsc_pkg.sv */
// types shared by the boundary-scan cell chain
// assumes the tap controller reports its state and instruction class in these types
package bsc_pkg;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR, TAP_PAUSE_DR, TAP_EXIT2_DR,
    TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } tap_state_t;

  typedef enum logic [2:0] {
    SCAN_NORMAL, SCAN_SAMPLE, SCAN_EXTEST, SCAN_CLAMP, SCAN_HIGHZ
  } scan_mode_t;

  typedef struct packed {
    tap_state_t state;
    scan_mode_t mode;
  } tap_ctl_t;

endpackage : bsc_pkg

/* File: bsc_chain.sv */
// boundary-scan cell chain: shift stages, update latches, pad muxing, serial output driver
// assumes a tap controller on i_ref_clk reports the state entered at each sampled test clock edge
`timescale 1ns/1ps
`include "bsc_defs.svh"

// ==========================================================
// snapshot fifo
module bsc_snap_fifo #(
  parameter int WIDTH = 46,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // filling side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // draining side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign o_in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data = mem[rd_q];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem[wr_q] <= i_in_data;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : bsc_snap_fifo

// ==========================================================
// chain top
module bsc_chain
  import bsc_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // test access pins
  input wire logic i_tck,
  input wire logic i_tdi,
  input wire logic i_trst_n,
  output logic o_tdo,
  output logic o_tdo_oe,
  // tap controller view, same clock
  input wire tap_ctl_t i_tap,
  input wire logic i_alt_tdo,
  // pads and core
  input wire logic [`CHAIN_MSB:0] i_pad_in,
  input wire logic [`CHAIN_MSB:0] i_core_out,
  input wire logic i_core_oe_mse,
  input wire logic i_core_oe_abe,
  output logic [`CHAIN_MSB:0] o_pad_out,
  output logic [`CHAIN_MSB:0] o_pad_oe,
  output logic [`CHAIN_MSB:0] o_core_in,
  // capture snapshot stream
  output logic o_snap_valid,
  output logic [`CHAIN_MSB:0] o_snap_data,
  input wire logic i_snap_ready,
  output logic o_snap_room
);
  localparam int N = `CHAIN_LEN;

  // ==========================================================
  // pin synchronisers and test clock edges
  logic [N+2:0] sync1_q;
  logic [N+2:0] sync2_q;
  logic tck_prev_q;
  logic tck_s;
  logic tdi_s;
  logic trst_n_s;
  logic [N-1:0] pad_in_s;
  logic rise;
  logic fall;

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sync1_q <= '0;
      sync2_q <= '0;
      tck_prev_q <= 1'b0;
    end else begin
      sync1_q <= {i_pad_in, i_trst_n, i_tdi, i_tck};
      sync2_q <= sync1_q;
      tck_prev_q <= tck_s;
    end
  end

  assign tck_s = sync2_q[0];
  assign tdi_s = sync2_q[1];
  assign trst_n_s = sync2_q[2];
  assign pad_in_s = sync2_q[N+2:3];
  // edges only, no watchdog, so a halted clock in either phase just waits
  assign rise = tck_s && !tck_prev_q;
  assign fall = !tck_s && tck_prev_q;

  // ==========================================================
  // shift stages and update latches
  logic [N-1:0] shift_q;
  logic [N-1:0] upd_q;
  logic [N-1:0] cap_vec;
  logic bs_sel;
  logic ext;
  logic in_shift;

  assign bs_sel = (i_tap.mode == SCAN_SAMPLE) || (i_tap.mode == SCAN_EXTEST);
  assign ext = (i_tap.mode == SCAN_EXTEST) || (i_tap.mode == SCAN_CLAMP) || (i_tap.mode == SCAN_HIGHZ);
  assign in_shift = (i_tap.state == TAP_SHIFT_DR) || (i_tap.state == TAP_SHIFT_IR);
  // input cells see the pad, output cells the level they drive
  assign cap_vec = (pad_in_s & `IN_MASK) | (o_pad_out & `OUT_MASK);

  // reset value is only for a clean simulation; software sees no meaning in it
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      shift_q <= '0;
    end else if (!trst_n_s) begin
      shift_q <= '0;
    end else if (rise && bs_sel && i_tap.state == TAP_CAP_DR) begin
      shift_q <= cap_vec;
    end else if (rise && bs_sel && i_tap.state == TAP_SHIFT_DR) begin
      shift_q <= {shift_q[N-2:0], tdi_s};
    end
  end

  // separate latch so shifting never ripples onto the pins
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      upd_q <= '0;
    end else if (!trst_n_s) begin
      upd_q <= '0;
    end else if (fall && bs_sel && i_tap.state == TAP_UPD_DR) begin
      upd_q <= shift_q;
    end
  end

  // ==========================================================
  // serial output, changes on the falling test clock edge
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_tdo <= 1'b0;
      o_tdo_oe <= 1'b0;
    end else if (fall) begin
      o_tdo <= bs_sel ? shift_q[N-1] : i_alt_tdo;
      o_tdo_oe <= in_shift;
    end
  end

  // ==========================================================
  // pad and core muxing
  logic [N-1:0] bs_oe;
  logic [N-1:0] core_oe;

  always_comb begin
    bs_oe = (`MSE_GATED & {N{upd_q[`MSE_BIT]}}) | (`ABE_GATED & {N{upd_q[`ABE_BIT]}}) | `UNGATED;
    core_oe = (`MSE_GATED & {N{i_core_oe_mse}}) | (`ABE_GATED & {N{i_core_oe_abe}}) | `UNGATED;
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pad_out <= '0;
      o_pad_oe <= '0;
    end else begin
      o_pad_out <= (ext ? upd_q : i_core_out) & `OUT_MASK;
      o_pad_oe <= (i_tap.mode == SCAN_HIGHZ) ? '0 : (ext ? bs_oe : core_oe);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_core_in <= '0;
    end else begin
      o_core_in <= ((i_tap.mode == SCAN_EXTEST) ? upd_q : pad_in_s) & `IN_MASK;
    end
  end

  // ==========================================================
  // capture snapshots; a full buffer drops the snapshot, never the capture
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [N-1:0] fifo_out_data;
  logic fifo_pop;

  assign fifo_pop = fifo_out_valid && (!o_snap_valid || i_snap_ready);

  bsc_snap_fifo #(
    .WIDTH(N),
    .DEPTH(`SNAP_DEPTH)
  ) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_in_valid(rise && bs_sel && trst_n_s && i_tap.state == TAP_CAP_DR),
    .i_in_data(cap_vec),
    .o_in_ready(fifo_in_ready),
    .o_out_valid(fifo_out_valid),
    .o_out_data(fifo_out_data),
    .i_out_ready(!o_snap_valid || i_snap_ready)
  );

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_snap_valid <= 1'b0;
      o_snap_data <= '0;
      o_snap_room <= 1'b0;
    end else begin
      o_snap_room <= fifo_in_ready;
      if (fifo_pop) begin
        o_snap_valid <= 1'b1;
        o_snap_data <= fifo_out_data;
      end else if (i_snap_ready) begin
        o_snap_valid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_cap;
    rise && bs_sel && trst_n_s && i_tap.state == TAP_CAP_DR;
  endsequence
  sequence s_shift;
    rise && bs_sel && trst_n_s && i_tap.state == TAP_SHIFT_DR;
  endsequence

  property p_capture;
    s_cap |=> shift_q == $past(cap_vec);
  endproperty
  a_capture: assert property (p_capture) else $error("capture value wrong");

  property p_shift;
    s_shift |=> shift_q[0] == $past(tdi_s) && shift_q[N-1:1] == $past(shift_q[N-2:0]);
  endproperty
  a_shift: assert property (p_shift) else $error("shift order wrong");

  property p_hold;
    trst_n_s && !(i_tap.state inside {TAP_CAP_DR, TAP_SHIFT_DR}) |=> $stable(shift_q);
  endproperty
  a_hold: assert property (p_hold) else $error("shift stage moved");

  property p_tdo_on;
    fall && in_shift |=> o_tdo_oe;
  endproperty
  a_tdo_on: assert property (p_tdo_on) else $error("tdo not driven in shift");

  property p_tdo_off;
    fall && !in_shift |=> !o_tdo_oe ##1 (o_tdo_oe == 1'b0 || $past(fall));
  endproperty
  a_tdo_off: assert property (p_tdo_off) else $error("tdo driven outside shift");

  property p_clamp;
    ((i_tap.mode == SCAN_CLAMP) && trst_n_s) [*2] |-> $stable(upd_q) ##1 o_pad_out == ($past(upd_q) & `OUT_MASK);
  endproperty
  a_clamp: assert property (p_clamp) else $error("clamp changed latches");

  property p_extest_core;
    $past(i_tap.mode == SCAN_EXTEST) |-> o_core_in == ($past(upd_q) & `IN_MASK);
  endproperty
  a_extest_core: assert property (p_extest_core) else $error("core not fed from latches");

  property p_sample_core;
    $past(i_tap.mode == SCAN_SAMPLE) |-> o_core_in == ($past(pad_in_s) & `IN_MASK) && o_pad_out == ($past(i_core_out) & `OUT_MASK);
  endproperty
  a_sample_core: assert property (p_sample_core) else $error("preload leaked");

  property p_enables;
    $past(i_tap.mode == SCAN_EXTEST) |-> o_pad_oe[13] && o_pad_oe[2] == $past(upd_q[`MSE_BIT]) && o_pad_oe[45] == $past(upd_q[`ABE_BIT]);
  endproperty
  a_enables: assert property (p_enables) else $error("enable cell mapping wrong");

endmodule : bsc_chain

/* File: bsc_tap_model.sv */
// test controller model: drives the test clock, serial input, test reset and the tap view
// assumes the bench calls one task at a time; the test clock stands low between calls
`timescale 1ns/1ps
module bsc_tap_model
  import bsc_pkg::*;
(
  // clock
  input wire logic i_clk,
  // test pins and tap view
  output logic o_tck,
  output logic o_tdi,
  output logic o_trst_n,
  output tap_ctl_t o_tap
);
  event smp;

  initial begin
    o_tck = 1'b0;
    o_tdi = 1'b1;
    o_trst_n = 1'b0;
    o_tap = '{TAP_RESET, SCAN_NORMAL};
  end

  // ==========================================================
  // test clock periods, each rising 1.3 ns after a falling system clock edge
  task automatic tick(input tap_state_t st, input logic d, input logic hold);
    @(negedge i_clk);
    o_tap.state = st;
    o_tdi = d;
    #1.3 o_tck = 1'b1;
    #62.5;
    if (hold) #2000;
    o_tck = 1'b0;
    if (hold) #2000;
    #60;
    // serial output is read late in the low phase, well after the falling edge
    -> smp;
  endtask : tick

  task automatic set_mode(input scan_mode_t m);
    @(negedge i_clk);
    o_tap.mode = m;
  endtask : set_mode

  task automatic treset();
    @(negedge i_clk);
    o_trst_n = 1'b0;
    o_tap.state = TAP_RESET;
    repeat (8) @(negedge i_clk);
    o_trst_n = 1'b1;
  endtask : treset
endmodule : bsc_tap_model

/* File: tb_top.sv */
// self-checking bench of the boundary-scan cell chain
// assumes the controller model owns the test pins; the bench owns pads, core and stream
`timescale 1ns/1ps
`include "bsc_defs.svh"
module tb_top import bsc_pkg::*;;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic alt = 1'b0;
  logic oe_mse = 1'b0;
  logic oe_abe = 1'b0;
  logic snap_ready = 1'b0;
  logic tck, tdi, trst_n, tdo, tdo_oe, snap_valid, snap_room;
  tap_ctl_t tap_v;
  logic [45:0] pad_in = '0;
  logic [45:0] core_out = '0;
  logic [45:0] pad_out, pad_oe, core_in, snap_data, g, d2, cap;
  logic [1:0] tdo_q[$];
  logic [45:0] snap_q[$];
  scan_mode_t md = SCAN_NORMAL;
  int bad_count = 0;
  int num_checks = 0;

  always #2 clk = ~clk;

  bsc_chain dut (.i_ref_clk(clk), .i_rstn(rstn), .i_tck(tck), .i_tdi(tdi), .i_trst_n(trst_n), .o_tdo(tdo),
    .o_tdo_oe(tdo_oe), .i_tap(tap_v), .i_alt_tdo(alt), .i_pad_in(pad_in), .i_core_out(core_out),
    .i_core_oe_mse(oe_mse), .i_core_oe_abe(oe_abe), .o_pad_out(pad_out), .o_pad_oe(pad_oe),
    .o_core_in(core_in), .o_snap_valid(snap_valid), .o_snap_data(snap_data), .i_snap_ready(snap_ready),
    .o_snap_room(snap_room));
  bsc_tap_model tap (.i_clk(clk), .o_tck(tck), .o_tdi(tdi), .o_trst_n(trst_n), .o_tap(tap_v));

  // ==========================================================
  // checking
  task automatic chk(input logic [137:0] seen, input logic [137:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  always @(tap.smp) begin
    if (tdo_q.size() == 0) begin
      // a serial output sample with nothing expected
      chk(138'(1), 138'(0));
    end else begin
      chk(138'({tdo_oe, tdo}), 138'(tdo_q.pop_front()));
    end
  end

  always @(posedge clk) begin
    if (snap_valid === 1'b1 && snap_ready) begin
      if (snap_q.size() == 0) begin
        // a snapshot that no capture asked for
        chk(138'(1), 138'(0));
      end else begin
        chk(138'(snap_data), 138'(snap_q.pop_front()));
      end
    end
  end

  // pads follow the update latch under extest, clamp and highz; highz drops every enable
  function automatic logic [137:0] pads(input scan_mode_t m, input logic [45:0] u);
    logic tst;
    logic [45:0] oe;
    tst = (m == SCAN_EXTEST) || (m == SCAN_CLAMP) || (m == SCAN_HIGHZ);
    oe = ({46{tst ? u[`MSE_BIT] : oe_mse}} & `MSE_GATED) | `UNGATED;
    oe = oe | ({46{tst ? u[`ABE_BIT] : oe_abe}} & `ABE_GATED);
    if (m == SCAN_HIGHZ) begin
      oe = '0;
    end
    return {(tst ? u : core_out) & `OUT_MASK, oe, ((m == SCAN_EXTEST) ? u : pad_in) & `IN_MASK};
  endfunction : pads

  task automatic chk_pads(input logic [45:0] u);
    repeat (4) @(negedge clk);
    chk({pad_out, pad_oe, core_in}, pads(md, u));
  endtask : chk_pads

  // ==========================================================
  // stimulus
  task automatic step(input tap_state_t s, input logic d, input logic hold, input logic [1:0] e);
    tdo_q.push_back(e);
    tap.tick(s, d, hold);
  endtask : step

  // capture, shift in din with a halted pause midway, then update
  task automatic scan(input logic [45:0] din, input logic [45:0] c, input logic [45:0] u);
    logic [91:0] v;
    v = {c, din};
    step(TAP_CAP_DR, 1'b0, 1'b0, {1'b0, c[45]});
    for (int j = 1; j <= 46; j++) begin
      step(TAP_SHIFT_DR, din[46-j], 1'b0, {1'b1, v[91-j]});
      if (j == 20) begin
        step(TAP_EXIT1_DR, 1'b0, 1'b0, {1'b0, v[71]});
        step(TAP_PAUSE_DR, 1'b1, 1'b1, {1'b0, v[71]});
        chk_pads(u);
        step(TAP_EXIT2_DR, 1'b1, 1'b0, {1'b0, v[71]});
      end
    end
    step(TAP_EXIT1_DR, 1'b0, 1'b0, {1'b0, din[45]});
    step(TAP_UPD_DR, 1'b1, 1'b0, {1'b0, din[45]});
  endtask : scan

  initial begin
    void'($urandom(32'h0405));
    repeat (16) @(posedge clk);
    @(negedge clk) rstn = 1'b1;
    tap.treset();
    pad_in = 46'({$urandom, $urandom});
    core_out = 46'({$urandom, $urandom});
    oe_mse = 1'b1;
    g = 46'({$urandom, $urandom});
    g[`MSE_BIT] = 1'b1;
    g[`ABE_BIT] = 1'b0;
    // guard values go in under sample/preload first
    md = SCAN_SAMPLE;
    tap.set_mode(md);
    chk_pads(g);
    cap = (pad_in & `IN_MASK) | (core_out & `OUT_MASK);
    snap_q.push_back(cap);
    scan(g, cap, g);
    chk_pads(g);
    // output register and eight buffer words fill while the consumer stalls; the ninth capture is dropped
    for (int i = 0; i < 9; i++) begin
      @(negedge clk) core_out = 46'({$urandom, $urandom});
      oe_abe = i[0];
      chk_pads(g);
      cap = (pad_in & `IN_MASK) | (core_out & `OUT_MASK);
      if (i < 8) snap_q.push_back(cap);
      step(TAP_CAP_DR, 1'b0, 1'b0, {1'b0, cap[45]});
      step(TAP_EXIT1_DR, 1'b0, 1'b0, {1'b0, cap[45]});
    end
    chk(138'(snap_room), 138'(0));
    @(negedge clk) snap_ready = 1'b1;
    repeat (40) @(negedge clk);
    chk(138'({snap_room, 32'(snap_q.size())}), 138'({1'b1, 32'h0}));
    md = SCAN_EXTEST;
    tap.set_mode(md);
    chk_pads(g);
    d2 = (46'({$urandom, $urandom}) & `OUT_MASK) | (g & `IN_MASK);
    cap = (pad_in & `IN_MASK) | (g & `OUT_MASK);
    snap_q.push_back(cap);
    scan(d2, cap, g);
    chk_pads(d2);
    md = SCAN_CLAMP;
    tap.set_mode(md);
    pad_in = 46'({$urandom, $urandom});
    chk_pads(d2);
    // under clamp the chain is refused and the serial output carries the other path
    for (int i = 0; i < 3; i++) begin
      @(negedge clk) alt = 1'($urandom);
      step(TAP_CAP_DR, 1'b0, 1'b0, {1'b0, alt});
      step(TAP_SHIFT_DR, 1'b1, 1'b0, {1'b1, alt});
      step(TAP_UPD_DR, 1'b0, 1'b0, {1'b0, alt});
      step(TAP_SHIFT_IR, 1'b1, 1'b0, {1'b1, alt});
      step(TAP_EXIT1_IR, 1'b0, 1'b0, {1'b0, alt});
      chk_pads(d2);
    end
    // highz turns every driver off, normal hands the pins back to the core
    md = SCAN_HIGHZ;
    tap.set_mode(md);
    chk_pads(d2);
    md = SCAN_NORMAL;
    tap.set_mode(md);
    chk_pads(d2);
    chk(138'(tdo_q.size() + snap_q.size()), 138'(0));
    end_of_test();
  end

  initial begin
    #200000;
    bad_count++;
    end_of_test();
  end
endmodule : tb_top
